// ### fsp_consts.vh
`ifndef FSP_CONSTS_VH
`define FSP_CONSTS_VH

// Register byte offsets
`define FSP_REG_LOCK       5'h00
`define FSP_REG_OP         5'h04
`define FSP_REG_STATUS     5'h08
`define FSP_REG_BOARD      5'h0c
`define FSP_REG_MUXADDR    5'h10

// Field layout
`define FSP_LOCK_W         7
`define FSP_LOCK_RST       7'h00
`define FSP_ADDR_W         18
`define FSP_KIND_LSB       18
`define FSP_KIND_MSB       19
`define FSP_ST_ACCEPT      0
`define FSP_ST_REJECT      1
`define FSP_ST_HUB         2
`define FSP_ST_MUX         3
`define FSP_ST_ID_LSB      4
`define FSP_ST_ID_MSB      7
`define FSP_ST_ARRAY       8
`define FSP_ST_BUSY        9

// Operation kinds
`define FSP_KIND_PROG      2'h0
`define FSP_KIND_ERASE_SEC 2'h1
`define FSP_KIND_ERASE_64K 2'h2

// Memory map
`define FSP_TOP_SECTOR     3'h6
`define FSP_TOP_REGION     2'h3

// AXI responses
`define FSP_RESP_OKAY      2'h0
`define FSP_RESP_SLVERR    2'h2

`endif

// ### fsp_protect.v
`timescale 1ns/1ps
`include "fsp_consts.vh"

module fsp_protect (
   opKind,
   opAddr,
   sectorLock,
   bootLockN,
   regionGuardN,
   deny
);
   input  wire [1:0]  opKind;
   input  wire [17:0] opAddr;
   input  wire [6:0]  sectorLock;
   input  wire        bootLockN;
   input  wire        regionGuardN;
   output reg         deny;

   // Sector index 0..6 of a byte address
   function [2:0] sectorOf;
      input [17:0] a;
      begin
         if (a[17:16] != `FSP_TOP_REGION)
            sectorOf = {1'b0, a[17:16]};
         else if (a[15] == 1'b0)
            sectorOf = 3'h3;
         else if (a[14] == 1'b1)
            sectorOf = `FSP_TOP_SECTOR;
         else
            sectorOf = a[13] ? 3'h5 : 3'h4;
      end
   endfunction

   reg [2:0] sec;
   reg       whole64;
   reg       topHit;
   reg       restHit;
   reg       lockHit;

   always @* begin
      sec     = sectorOf(opAddr);
      whole64 = (opKind == `FSP_KIND_ERASE_64K);
      if (whole64) begin
         // Top 64K erase covers sectors 3..6
         topHit  = (opAddr[17:16] == `FSP_TOP_REGION);
         restHit = 1'b1;
         if (opAddr[17:16] == `FSP_TOP_REGION)
            lockHit = |sectorLock[6:3];
         else
            lockHit = sectorLock[opAddr[17:16]];
      end else begin
         topHit  = (sec == `FSP_TOP_SECTOR);
         restHit = (sec != `FSP_TOP_SECTOR);
         lockHit = sectorLock[sec];
      end
      // Pins only gate; lock bits always apply
      deny = lockHit
           | (topHit & ~bootLockN)
           | (restHit & ~regionGuardN);
   end
endmodule // fsp_protect

// ### fsp_mux_addr.v
`timescale 1ns/1ps
`include "fsp_consts.vh"

module fsp_mux_addr (
   sys_clk,
   rstn,
   enable,
   rowCol,
   addrPins,
   muxAddr
);
   input  wire        sys_clk;
   input  wire        rstn;
   input  wire        enable;
   input  wire        rowCol;
   input  wire [10:0] addrPins;
   output wire [17:0] muxAddr;

   reg        rowColPrev_q;
   reg [10:0] low_q;
   reg [6:0]  high_q;

   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rowColPrev_q <= 1'b1;
         low_q        <= 11'h000;
         high_q       <= 7'h00;
      end else begin
         rowColPrev_q <= rowCol;
         if (enable && rowColPrev_q && !rowCol)
            low_q <= addrPins;
         if (enable && !rowColPrev_q && rowCol)
            high_q <= addrPins[6:0];
      end
   end

   assign muxAddr = {high_q, low_q};
endmodule // fsp_mux_addr

// ### fsp_top.v
`timescale 1ns/1ps
`include "fsp_consts.vh"

module fsp_top (
   sys_clk,
   rstn,
   secResetN,
   bootLockN,
   regionGuardN,
   strapIdentity,
   boardInputs,
   portSelect,
   rowCol,
   hubMode,
   cycleId,
   cycleForUs,
   busDriveAllow,
   muxOutEnable,
   writeInhibit,
   automationReset,
   opStart,
   opKind,
   opAddr,
   opDone,
   muxAddr,
   s_axi_awaddr,
   s_axi_awvalid,
   s_axi_awready,
   s_axi_wdata,
   s_axi_wstrb,
   s_axi_wvalid,
   s_axi_wready,
   s_axi_bresp,
   s_axi_bvalid,
   s_axi_bready,
   s_axi_araddr,
   s_axi_arvalid,
   s_axi_arready,
   s_axi_rdata,
   s_axi_rresp,
   s_axi_rvalid,
   s_axi_rready
);
   input  wire        sys_clk;
   input  wire        rstn;
   input  wire        secResetN;
   input  wire        bootLockN;
   input  wire        regionGuardN;
   input  wire [3:0]  strapIdentity;
   input  wire [4:0]  boardInputs;
   input  wire        portSelect;
   input  wire        rowCol;
   input  wire        hubMode;
   input  wire [3:0]  cycleId;
   output wire        cycleForUs;
   output wire        busDriveAllow;
   output wire        muxOutEnable;
   output wire        writeInhibit;
   output wire        automationReset;
   output reg         opStart;
   output reg  [1:0]  opKind;
   output reg  [17:0] opAddr;
   input  wire        opDone;
   output wire [17:0] muxAddr;
   input  wire [4:0]  s_axi_awaddr;
   input  wire        s_axi_awvalid;
   output wire        s_axi_awready;
   input  wire [31:0] s_axi_wdata;
   input  wire [3:0]  s_axi_wstrb;
   input  wire        s_axi_wvalid;
   output wire        s_axi_wready;
   output reg  [1:0]  s_axi_bresp;
   output reg         s_axi_bvalid;
   input  wire        s_axi_bready;
   input  wire [4:0]  s_axi_araddr;
   input  wire        s_axi_arvalid;
   output wire        s_axi_arready;
   output reg  [31:0] s_axi_rdata;
   output reg  [1:0]  s_axi_rresp;
   output reg         s_axi_rvalid;
   input  wire        s_axi_rready;

   reg        portSel_q;
   reg        selTaken_q;
   reg [6:0]  sectorLock_q;
   reg        reqPend_q;
   reg [1:0]  reqKind_q;
   reg [17:0] reqAddr_q;
   reg        accepted_q;
   reg        rejected_q;
   reg        busy_q;
   reg        readArray_q;

   wire       inReset;
   wire       denied;
   wire       wrFire;
   wire       rdFire;
   wire [10:0] addrPins;
   wire       wrLock;
   wire       wrOp;

   // Secondary reset is an in-system reset; in mux mode its pin is OE
   assign inReset = !secResetN && !portSel_q;

   // Port select is caught while held in reset and at release
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         portSel_q  <= 1'b0;
         selTaken_q <= 1'b0;
      end else if (!selTaken_q || inReset) begin
         portSel_q  <= portSelect;
         selTaken_q <= 1'b1;
      end
   end

   assign writeInhibit    = inReset || !selTaken_q;
   assign automationReset = inReset || !selTaken_q;
   assign busDriveAllow   = !portSel_q && !inReset
                            && selTaken_q;
   assign muxOutEnable    = portSel_q && selTaken_q
                            && !secResetN;

   // Identity compare only for hub cycles
   assign cycleForUs = !portSel_q
                       && (!hubMode
                           || cycleId == strapIdentity);

   // Mux address pins reuse the sideband inputs
   assign addrPins = {boardInputs, regionGuardN, bootLockN,
                      strapIdentity};

   fsp_mux_addr u_muxAddr (
      .sys_clk  (sys_clk),
      .rstn     (rstn),
      .enable   (portSel_q),
      .rowCol   (rowCol),
      .addrPins (addrPins),
      .muxAddr  (muxAddr)
   );

   fsp_protect u_protect (
      .opKind       (reqKind_q),
      .opAddr       (reqAddr_q),
      .sectorLock   (sectorLock_q),
      .bootLockN    (bootLockN),
      .regionGuardN (regionGuardN),
      .deny         (denied)
   );

   // AXI4-Lite: address and data taken together, one at a time
   assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   assign s_axi_wready  = s_axi_awready;
   assign wrFire        = s_axi_awready;
   assign s_axi_arready = !s_axi_rvalid;
   assign rdFire        = s_axi_arvalid && s_axi_arready;

   // Write side effects share one decode
   assign wrLock        = wrFire && s_axi_awaddr == `FSP_REG_LOCK;
   assign wrOp          = wrFire && s_axi_awaddr == `FSP_REG_OP;

   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `FSP_RESP_OKAY;
      end else if (wrFire) begin
         s_axi_bvalid <= 1'b1;
         if (s_axi_awaddr == `FSP_REG_LOCK || s_axi_awaddr == `FSP_REG_OP)
            s_axi_bresp <= `FSP_RESP_OKAY;
         else
            s_axi_bresp <= `FSP_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Lock bits change only by software or reset, never by pins
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         sectorLock_q <= `FSP_LOCK_RST;
      end else if (inReset) begin
         sectorLock_q <= `FSP_LOCK_RST;
      end else if (wrLock && s_axi_wstrb[0]) begin
         sectorLock_q <= s_axi_wdata[6:0];
      end
   end

   // Operation request capture
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         reqPend_q <= 1'b0;
         reqKind_q <= `FSP_KIND_PROG;
         reqAddr_q <= 18'h00000;
      end else begin
         reqPend_q <= wrOp && (&s_axi_wstrb[2:0]);
         if (wrOp) begin
            reqKind_q <= s_axi_wdata[`FSP_KIND_MSB:`FSP_KIND_LSB];
            reqAddr_q <= s_axi_wdata[17:0];
         end
      end
   end

   // Check pins and locks at acceptance
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         opStart     <= 1'b0;
         opKind      <= `FSP_KIND_PROG;
         opAddr      <= 18'h00000;
         accepted_q  <= 1'b0;
         rejected_q  <= 1'b0;
         busy_q      <= 1'b0;
         readArray_q <= 1'b1;
      end else if (inReset) begin
         opStart     <= 1'b0;
         busy_q      <= 1'b0;
         readArray_q <= 1'b1;
         if (reqPend_q) begin
            accepted_q <= 1'b0;
            rejected_q <= 1'b1;
         end
      end else begin
         opStart <= 1'b0;
         // Done is taken even when a refused request lands alongside
         if (opDone && busy_q) begin
            busy_q      <= 1'b0;
            readArray_q <= 1'b1;
         end
         if (reqPend_q) begin
            if (denied || busy_q || writeInhibit
                || reqKind_q == 2'h3) begin
               accepted_q <= 1'b0;
               rejected_q <= 1'b1;
            end else begin
               accepted_q  <= 1'b1;
               rejected_q  <= 1'b0;
               opStart     <= 1'b1;
               opKind      <= reqKind_q;
               opAddr      <= reqAddr_q;
               busy_q      <= 1'b1;
               readArray_q <= 1'b0;
            end
         end
      end
   end

   // Read side
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= `FSP_RESP_OKAY;
      end else if (rdFire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= `FSP_RESP_OKAY;
         s_axi_rdata  <= 32'h00000000;
         case (s_axi_araddr)
            `FSP_REG_LOCK:
               s_axi_rdata[6:0] <= sectorLock_q;
            `FSP_REG_OP:
               s_axi_rdata[19:0] <= {reqKind_q, reqAddr_q};
            `FSP_REG_STATUS: begin
               s_axi_rdata[`FSP_ST_ACCEPT] <= accepted_q;
               s_axi_rdata[`FSP_ST_REJECT] <= rejected_q;
               s_axi_rdata[`FSP_ST_HUB]    <= hubMode;
               s_axi_rdata[`FSP_ST_MUX]    <= portSel_q;
               s_axi_rdata[`FSP_ST_ID_MSB:`FSP_ST_ID_LSB] <= strapIdentity;
               s_axi_rdata[`FSP_ST_ARRAY]  <= readArray_q;
               s_axi_rdata[`FSP_ST_BUSY]   <= busy_q;
            end
            `FSP_REG_BOARD:
               s_axi_rdata[4:0] <= boardInputs;
            `FSP_REG_MUXADDR:
               s_axi_rdata[17:0] <= muxAddr;
            default:
               s_axi_rresp <= `FSP_RESP_SLVERR;
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule // fsp_top

// ### fsp_top_chk.sv
`timescale 1ns/1ps
module fsp_chk (
   input logic       sys_clk,
   input logic       rstn,
   input logic       secResetN,
   input logic       portSelect,
   input logic       hubMode,
   input logic [3:0] cycleId,
   input logic [3:0] strapIdentity,
   input logic       cycleForUs,
   input logic       busDriveAllow,
   input logic       muxOutEnable,
   input logic       writeInhibit,
   input logic       automationReset,
   input logic       opStart,
   input logic       opDone,
   input logic       s_axi_awvalid,
   input logic       s_axi_wvalid,
   input logic       s_axi_bvalid,
   input logic       s_axi_bready,
   input logic       s_axi_arvalid,
   input logic       s_axi_rvalid
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   property p_inhTie; writeInhibit == automationReset; endproperty
   a_inhTie: assert property (p_inhTie) else $error("inhibit split");
   property p_secRst;
      !portSelect && !secResetN ##1 !secResetN
         |-> writeInhibit && !busDriveAllow && !opStart;
   endproperty
   a_secRst: assert property (p_secRst) else $error("second reset");
   property p_opPulse; opStart |=> (!opStart) [*2]; endproperty
   a_opPulse: assert property (p_opPulse) else $error("op pulse");
   property p_busyBlk;
      opStart ##1 (!opDone && secResetN) [*4] |-> !opStart;
   endproperty
   a_busyBlk: assert property (p_busyBlk) else $error("start busy");
   property p_wrAns;
      s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid;
   endproperty
   a_wrAns: assert property (p_wrAns) else $error("no write answer");
   property p_bHold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
   a_bHold: assert property (p_bHold) else $error("bvalid dropped");
   property p_rdAns; s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid; endproperty
   a_rdAns: assert property (p_rdAns) else $error("no read answer");
   property p_idMiss;
      hubMode && cycleId != strapIdentity |-> !cycleForUs;
   endproperty
   a_idMiss: assert property (p_idMiss) else $error("id mismatch taken");
   property p_noHub;
      !writeInhibit && !portSelect && !hubMode |-> cycleForUs;
   endproperty
   a_noHub: assert property (p_noHub) else $error("plain cycle lost");
   property p_muxOe; muxOutEnable |-> portSelect && !secResetN; endproperty
   a_muxOe: assert property (p_muxOe) else $error("mux oe");
   c_op: cover property (opStart);
   c_wr: cover property (s_axi_bvalid && s_axi_bready);
   c_oe: cover property (muxOutEnable);
endmodule // fsp_chk

bind fsp_top fsp_chk u_chk (.sys_clk, .rstn, .secResetN, .portSelect,
   .hubMode, .cycleId, .strapIdentity, .cycleForUs, .busDriveAllow,
   .muxOutEnable, .writeInhibit, .automationReset, .opStart, .opDone,
   .s_axi_awvalid, .s_axi_wvalid, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_rvalid);

// ### fsp_auto_model.sv
`timescale 1ns/1ps
module fsp_auto_model (
   input logic       sys_clk,
   input logic       rstn,
   input logic       opStart,
   input logic [3:0] lat,
   output logic      opDone
);
   logic [3:0] cnt_q;
   // Finishes each started operation lat+1 cycles after opStart when lat is nonzero, prompt or slow
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         cnt_q  <= 4'h0;
         opDone <= 1'b0;
      end else begin
         opDone <= cnt_q == 4'h1;
         if (opStart) cnt_q <= lat;
         else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
      end
   end
endmodule // fsp_auto_model

// ### test_flash_sideband_protect_id_gpi.sv
`timescale 1ns/1ps
module test_flash_sideband_protect_id_gpi;
   logic        sys_clk = 0, rstn = 0, secResetN = 1, portSelect = 0;
   logic        bootLockN = 1, regionGuardN = 1, rowCol = 1, hubMode = 0;
   logic [3:0]  strapIdentity = 0, cycleId = 0, lat = 4'h1;
   logic [4:0]  boardInputs = 0, s_axi_awaddr = 0, s_axi_araddr = 0;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0;
   logic [31:0] s_axi_wdata = 0, rdv;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [1:0]  resp;
   wire         cycleForUs, busDriveAllow, muxOutEnable, writeInhibit;
   wire         automationReset, opStart, opDone, s_axi_awready;
   wire         s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0]   opKind, s_axi_bresp, s_axi_rresp;
   wire [17:0]  opAddr, muxAddr;
   wire [31:0]  s_axi_rdata;
   integer      bad_count = 0, n_checks = 0, cyc = 0;

   fsp_top dut (.sys_clk, .rstn, .secResetN, .bootLockN, .regionGuardN,
      .strapIdentity, .boardInputs, .portSelect, .rowCol, .hubMode,
      .cycleId, .cycleForUs, .busDriveAllow, .muxOutEnable, .writeInhibit,
      .automationReset, .opStart, .opKind, .opAddr, .opDone, .muxAddr,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   fsp_auto_model model (.sys_clk, .rstn, .opStart, .lat, .opDone);

   always #4 sys_clk = ~sys_clk;

   task final_report;
      begin
         $display("checks %0d mismatches %0d", n_checks, bad_count);
         if (bad_count == 0 && n_checks > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask

   always @(posedge sys_clk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         bad_count = bad_count + 1;
         final_report;
      end
   end

   task chk(input [31:0] s, input [31:0] e);
      begin
         n_checks = n_checks + 1;
         if (s !== e) begin
            bad_count = bad_count + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
         end
      end
   endtask

   task wr(input [4:0] a, input [31:0] d);
      begin
         s_axi_awaddr  <= a;
         s_axi_wdata   <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid  <= 1'b1;
         do @(posedge sys_clk); while (!(s_axi_awready && s_axi_wready));
         s_axi_awvalid <= 1'b0;
         s_axi_wvalid  <= 1'b0;
         s_axi_bready  <= 1'b1;
         do @(posedge sys_clk); while (!s_axi_bvalid);
         resp = s_axi_bresp;
         s_axi_bready <= 1'b0;
      end
   endtask

   task rd(input [4:0] a);
      begin
         s_axi_araddr  <= a;
         s_axi_arvalid <= 1'b1;
         do @(posedge sys_clk); while (!s_axi_arready);
         s_axi_arvalid <= 1'b0;
         s_axi_rready  <= 1'b1;
         do @(posedge sys_clk); while (!s_axi_rvalid);
         rdv  = s_axi_rdata;
         resp = s_axi_rresp;
         s_axi_rready <= 1'b0;
      end
   endtask

   // Sets the guard pins and locks, asks for one operation, waits idle
   task op(input bl, input rg, input [6:0] lk, input [1:0] k,
           input [17:0] a, input [1:0] st);
      begin
         bootLockN    <= bl;
         regionGuardN <= rg;
         wr(5'h00, {25'h0, lk});
         wr(5'h04, {12'h0, k, a});
         rd(5'h08);
         chk(rdv[1:0], st);
         if (st == 2'h1) begin
            chk(opAddr, a);
            chk(opKind, k);
         end
         rd(5'h00);
         chk(rdv, lk);
         rd(5'h08);
         while (rdv[9]) rd(5'h08);
      end
   endtask

   initial begin
      repeat (5) @(posedge sys_clk);
      rstn <= 1'b1;
      rd(5'h08);
      chk(rdv[8], 1'b1);
      chk(rdv[7:4], 4'h0);
      rd(5'h14);
      chk(resp, 2'h2);
      wr(5'h08, 32'h0);
      chk(resp, 2'h2);
      boardInputs <= 5'h15;
      @(posedge sys_clk);
      rd(5'h0c);
      chk(rdv, 32'h15);
      $display("test regs done");
      op(0, 1, 7'h00, 2'h0, 18'h3c000, 2'h2);
      op(1, 1, 7'h00, 2'h0, 18'h3c000, 2'h1);
      op(1, 1, 7'h40, 2'h0, 18'h3c000, 2'h2);
      op(0, 1, 7'h00, 2'h1, 18'h38000, 2'h1);
      op(0, 1, 7'h00, 2'h2, 18'h30000, 2'h2);
      op(1, 0, 7'h00, 2'h0, 18'h10000, 2'h2);
      op(1, 1, 7'h00, 2'h0, 18'h10000, 2'h1);
      op(1, 1, 7'h02, 2'h0, 18'h10000, 2'h2);
      op(1, 1, 7'h00, 2'h3, 18'h00000, 2'h2);
      lat <= 4'hf;
      wr(5'h04, 32'h0);
      wr(5'h04, 32'h0);
      rd(5'h08);
      chk(rdv[1:0], 2'h2);
      while (rdv[9]) rd(5'h08);
      $display("test protect done");
      strapIdentity <= 4'h1;
      hubMode       <= 1'b1;
      cycleId       <= 4'h1;
      @(negedge sys_clk) chk(cycleForUs, 1'b1);
      @(posedge sys_clk) cycleId <= 4'h0;
      @(negedge sys_clk) chk(cycleForUs, 1'b0);
      @(posedge sys_clk) hubMode <= 1'b0;
      @(negedge sys_clk) chk(cycleForUs, 1'b1);
      rd(5'h08);
      chk(rdv[7:4], 4'h1);
      $display("test ident done");
      wr(5'h00, 32'h7f);
      secResetN <= 1'b0;
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk) chk(busDriveAllow, 1'b0);
      chk(writeInhibit, 1'b1);
      chk(automationReset, 1'b1);
      @(posedge sys_clk) secResetN <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rd(5'h00);
      chk(rdv, 32'h0);
      rd(5'h08);
      chk(rdv[8], 1'b1);
      $display("test reset pin done");
      rstn       <= 1'b0;
      portSelect <= 1'b1;
      repeat (5) @(posedge sys_clk);
      rstn <= 1'b1;
      {boardInputs, regionGuardN, bootLockN, strapIdentity} <= 11'h5a3;
      repeat (2) @(posedge sys_clk);
      rowCol <= 1'b0;
      repeat (3) @(posedge sys_clk);
      {boardInputs, regionGuardN, bootLockN, strapIdentity} <= 11'h04b;
      repeat (2) @(posedge sys_clk);
      rowCol <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rd(5'h10);
      chk(rdv, {14'h0, 7'h4b, 11'h5a3});
      chk(muxAddr, {7'h4b, 11'h5a3});
      rd(5'h08);
      chk(rdv[3], 1'b1);
      secResetN <= 1'b0;
      @(negedge sys_clk) chk(muxOutEnable, 1'b1);
      $display("test mux done");
      final_report;
   end
endmodule // test_flash_sideband_protect_id_gpi
